// >>> inc/fast_parallel_consts.svh
// Contract
// RQ1 - x8: ratio 1, or 2 with decompression
// RQ2 - x16: 1 plain, 2 security, 4 decompression
// RQ3 - x32: 1 plain, 4 security, 8 decompression
// RQ4 - host presents one word per ratio clocks
// RQ5 - extra clocks decrypt and decompress word
// RQ6 - host clocks ratio minus one after last
// RQ7 - host waits 2 us or 1506 us first
// RQ8 - capture first edge of group, ignore rest
`ifndef FAST_PARALLEL_CONSTS_SVH
`define FAST_PARALLEL_CONSTS_SVH

`define CTRL_OFF 12'h000
`define KEY_OFF 12'h004
`define STAT_OFF 12'h008
`define COUNT_OFF 12'h00c
`define WORD_OFF 12'h010
`define FLAG_OFF 12'h014

`define CTRL_EN_BIT 0
`define CTRL_WIDTH_LO 1
`define CTRL_WIDTH_HI 2
`define CTRL_DECOMP_BIT 3
`define CTRL_SEC_BIT 4
`define CTRL_RESET 5'h00

`define FLAG_EARLY_BIT 0
`define FLAG_PARTIAL_BIT 1
`define FLAG_WIDTH_BIT 2

`define WIDTH_X8 2'h0
`define WIDTH_X16 2'h1
`define WIDTH_X32 2'h2

`define RATIO_1 4'h1
`define RATIO_2 4'h2
`define RATIO_4 4'h4
`define RATIO_8 4'h8

`define PCLK_MHZ 10
`define STATUS_GAP_US 2
`define RELEASE_GAP_US 1506
`define STATUS_GAP_CYC (`STATUS_GAP_US * `PCLK_MHZ)
`define RELEASE_GAP_CYC (`RELEASE_GAP_US * `PCLK_MHZ)

`endif

// >>> inc/fast_parallel_pkg.sv
package fast_parallel_pkg;
    typedef logic [1:0] bus_width_t;
    typedef logic [3:0] ratio_t;
    typedef enum logic [1:0] {
        intake_off,
        intake_wait,
        intake_run
    } intake_state_t;
endpackage

// >>> src/fast_parallel_intake.sv
// The placing of the registers and the APB register port were left to the implementer.
`timescale 1ns/1ns
`include "fast_parallel_consts.svh"
module fast_parallel_intake #(
    parameter int unsigned RELEASE_CYC = `RELEASE_GAP_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic config_clock,
    input wire logic [31:0] config_data,
    output logic [31:0] word_data,
    output logic word_valid,
    output logic busy
);
    fast_parallel_pkg::intake_state_t state_r;
    fast_parallel_pkg::ratio_t ratio_now;
    fast_parallel_pkg::ratio_t ratio_r;
    fast_parallel_pkg::ratio_t phase_r;
    logic [4:0] ctrl_r;
    logic [31:0] key_r;
    logic [31:0] count_r;
    logic [2:0] flag_r;
    logic [31:0] prdata_r;
    logic [15:0] wait_r;
    logic clk_d_r;
    logic word_valid_r;
    logic width_bad;
    logic en;
    logic rise;
    logic capture;
    logic step;
    logic last_step;
    logic wr;
    logic setup;
    logic hit;
    logic [31:0] data_masked;

    assign en = ctrl_r[`CTRL_EN_BIT];
    assign setup = psel & ~penable;
    assign wr = psel & penable & pwrite;
    assign pready = 1'b1;
    assign hit = (paddr == `CTRL_OFF) || (paddr == `KEY_OFF) ||
        (paddr == `STAT_OFF) || (paddr == `COUNT_OFF) ||
        (paddr == `WORD_OFF) || (paddr == `FLAG_OFF);
    assign pslverr = psel & penable & ~hit;
    assign prdata = prdata_r;
    assign word_valid = word_valid_r;
    assign busy = (phase_r != 4'h0);

    fast_parallel_ratio u_ratio (
        .width(ctrl_r[`CTRL_WIDTH_HI:`CTRL_WIDTH_LO]),
        .decomp_en(ctrl_r[`CTRL_DECOMP_BIT]),
        .sec_en(ctrl_r[`CTRL_SEC_BIT]),
        .ratio(ratio_now),
        .width_bad(width_bad)
    );

    // config clock is taken as synchronous to pclk; edge found here
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            clk_d_r <= 1'b0;
        else
            clk_d_r <= config_clock;
    end
    assign rise = config_clock & ~clk_d_r &
        (state_r != fast_parallel_pkg::intake_off);

    assign capture = rise && (phase_r == 4'h0); // RQ8
    assign step = rise && (phase_r != 4'h0); // RQ5
    assign last_step = step && (phase_r == ratio_r - 4'h1); // RQ4

    always_comb begin
        unique case (ctrl_r[`CTRL_WIDTH_HI:`CTRL_WIDTH_LO])
            `WIDTH_X8: data_masked = {24'h0, config_data[7:0]};
            `WIDTH_X16: data_masked = {16'h0, config_data[15:0]};
            default: data_masked = config_data;
        endcase
    end

    // host must not clock before the release wait; an early edge is flagged but still captured
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= fast_parallel_pkg::intake_off;
            wait_r <= 16'h0;
        end else begin
            unique case (state_r)
                fast_parallel_pkg::intake_off: begin
                    wait_r <= 16'h0;
                    if (en) state_r <= fast_parallel_pkg::intake_wait;
                end
                fast_parallel_pkg::intake_wait: begin
                    wait_r <= wait_r + 16'h1;
                    if (!en)
                        state_r <= fast_parallel_pkg::intake_off;
                    else if (wait_r == 16'(RELEASE_CYC - 1))
                        state_r <= fast_parallel_pkg::intake_run;
                end
                fast_parallel_pkg::intake_run: begin
                    if (!en) state_r <= fast_parallel_pkg::intake_off;
                end
                default: begin
                    state_r <= fast_parallel_pkg::intake_off;
                end
            endcase
        end
    end

    // group phase: edge 0 captures, the rest feed the unpack engine
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_r <= 4'h0;
            ratio_r <= `RATIO_1;
        end else if (!en) begin
            phase_r <= 4'h0;
        end else if (capture) begin
            ratio_r <= ratio_now; // RQ1 RQ2 RQ3
            phase_r <= (ratio_now == `RATIO_1) ? 4'h0 : 4'h1;
        end else if (last_step) begin
            phase_r <= 4'h0; // RQ4
        end else if (step) begin
            phase_r <= phase_r + 4'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            word_valid_r <= 1'b0;
        else
            word_valid_r <= (capture && ratio_now == `RATIO_1) ||
                last_step; // RQ5
    end

    fast_parallel_unpack u_unpack (
        .pclk(pclk),
        .presetn(presetn),
        .load(capture),
        .step(step),
        .sec_en(ctrl_r[`CTRL_SEC_BIT]),
        .decomp_en(ctrl_r[`CTRL_DECOMP_BIT]),
        .key(key_r),
        .din(data_masked),
        .dout_r(word_data)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= `CTRL_RESET;
            key_r <= 32'h0;
        end else if (wr && paddr == `CTRL_OFF) begin
            ctrl_r <= pwdata[4:0];
        end else if (wr && paddr == `KEY_OFF) begin
            key_r <= pwdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            count_r <= 32'h0;
        else if (wr && paddr == `COUNT_OFF)
            count_r <= 32'h0;
        else if (capture)
            count_r <= count_r + 32'h1; // RQ8
    end

    // sticky flags, write one to clear; a new event beats the clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_r <= 3'h0;
        end else begin
            flag_r <= (flag_r & ~((wr && paddr == `FLAG_OFF) ?
                pwdata[2:0] : 3'h0)) | {
                width_bad & en,
                busy & wr & (paddr == `CTRL_OFF) &
                    ~pwdata[`CTRL_EN_BIT],
                rise & (state_r == fast_parallel_pkg::intake_wait)};
        end
    end

    // read data loaded in setup so the access phase needs no wait
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h0;
        end else if (setup) begin
            unique case (paddr)
                `CTRL_OFF: prdata_r <= {27'h0, ctrl_r};
                `KEY_OFF: prdata_r <= 32'h0;
                `STAT_OFF: prdata_r <= {22'h0, state_r, phase_r,
                    ratio_r};
                `COUNT_OFF: prdata_r <= count_r;
                `WORD_OFF: prdata_r <= word_data;
                `FLAG_OFF: prdata_r <= {29'h0, flag_r};
                default: prdata_r <= 32'h0;
            endcase
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence last_edge_s;
        step && (phase_r == ratio_r - 4'h1);
    endsequence

    sequence first_edge_s;
        rise && (phase_r == 4'h0);
    endsequence

    sequence wait_mid_s;
        state_r == fast_parallel_pkg::intake_wait && en &&
            wait_r != 16'(RELEASE_CYC - 1);
    endsequence

    sequence wait_end_s;
        state_r == fast_parallel_pkg::intake_wait && en &&
            wait_r == 16'(RELEASE_CYC - 1);
    endsequence

    x8_plain_a: assert property ( // RQ1
        ctrl_r[2:1] == `WIDTH_X8 && !ctrl_r[3] |-> ratio_now == 4'h1)
        else $error("x8 ratio not 1");
    x8_decomp_a: assert property ( // RQ1
        ctrl_r[2:1] == `WIDTH_X8 && ctrl_r[3] |-> ratio_now == 4'h2)
        else $error("x8 decompress ratio not 2");
    x16_ratio_a: assert property ( // RQ2
        ctrl_r[2:1] == `WIDTH_X16 |-> ratio_now ==
        (ctrl_r[3] ? 4'h4 : (ctrl_r[4] ? 4'h2 : 4'h1)))
        else $error("x16 ratio wrong");
    x32_ratio_a: assert property ( // RQ3
        ctrl_r[2:1] == `WIDTH_X32 |-> ratio_now ==
        (ctrl_r[3] ? 4'h8 : (ctrl_r[4] ? 4'h4 : 4'h1)))
        else $error("x32 ratio wrong");
    capture_count_a: assert property ( // RQ8
        first_edge_s and en |=> count_r == $past(count_r) + 32'h1 ||
        $past(wr && paddr == `COUNT_OFF))
        else $error("word not counted on first edge");
    ignore_edge_a: assert property ( // RQ8
        step && !(wr && paddr == `COUNT_OFF) |=> $stable(count_r))
        else $error("word taken on later edge");
    group_wrap_a: assert property ( // RQ4
        last_edge_s and en |=> phase_r == 4'h0 ##0 word_valid)
        else $error("group did not close");
    valid_cause_a: assert property ( // RQ5
        word_valid |-> $past(last_step) ||
        ($past(capture) && $past(ratio_now) == 4'h1))
        else $error("word valid without its group end");
    phase_bound_a: assert property ( // RQ8
        busy |-> phase_r < ratio_r && ratio_r != 4'h1)
        else $error("phase past ratio");
    // group start and word path
    load_plain_a: assert property ( // RQ8
        capture && !ctrl_r[`CTRL_DECOMP_BIT] && !ctrl_r[`CTRL_SEC_BIT] |=>
        word_data == $past(data_masked))
        else $error("plain word not taken from the bus");
    single_word_a: assert property ( // RQ1
        capture && ratio_now == `RATIO_1 |=> word_valid && !busy)
        else $error("ratio one word not closed at once");
    group_open_a: assert property ( // RQ8
        capture && en && ratio_now != `RATIO_1 |=>
        busy && ratio_r == $past(ratio_now))
        else $error("group did not open with latched ratio");
    step_advance_a: assert property ( // RQ5
        step && !last_step && en |=> phase_r == $past(phase_r) + 4'h1)
        else $error("extra edge did not advance the group");
    word_hold_a: assert property ( // RQ5
        !capture && !step |=> $stable(word_data))
        else $error("word changed without an edge");
    ratio_hold_a: assert property ( // RQ8
        busy && wr && paddr == `CTRL_OFF |=> $stable(ratio_r))
        else $error("ratio changed inside a group");
    // control, release wait, flags and count
    off_state_a: assert property (
        !en |=> state_r == fast_parallel_pkg::intake_off &&
        phase_r == 4'h0)
        else $error("disable did not stop intake");
    release_hold_a: assert property (
        wait_mid_s |=> state_r == fast_parallel_pkg::intake_wait &&
        wait_r == $past(wait_r) + 16'h1)
        else $error("release wait left early");
    release_done_a: assert property (
        wait_end_s |=> state_r == fast_parallel_pkg::intake_run)
        else $error("release wait did not end");
    early_flag_a: assert property (
        rise && state_r == fast_parallel_pkg::intake_wait |=>
        flag_r[`FLAG_EARLY_BIT])
        else $error("early clock rise not flagged");
    width_flag_a: assert property (
        width_bad && en |=> flag_r[`FLAG_WIDTH_BIT])
        else $error("reserved width not flagged");
    drop_flag_a: assert property (
        busy && wr && paddr == `CTRL_OFF && !pwdata[`CTRL_EN_BIT] |=>
        flag_r[`FLAG_PARTIAL_BIT])
        else $error("cut group not flagged");
    flag_clear_a: assert property (
        wr && paddr == `FLAG_OFF && pwdata[`FLAG_EARLY_BIT] &&
        !(rise && state_r == fast_parallel_pkg::intake_wait) |=>
        !flag_r[`FLAG_EARLY_BIT])
        else $error("early flag not cleared");
    count_clear_a: assert property (
        wr && paddr == `COUNT_OFF |=> count_r == 32'h0)
        else $error("count not cleared");
    ctrl_write_a: assert property (
        wr && paddr == `CTRL_OFF |=> ctrl_r == $past(pwdata[4:0]))
        else $error("control write lost");
    read_count_a: assert property (
        setup && paddr == `COUNT_OFF |=> prdata == $past(count_r))
        else $error("count read wrong");
endmodule // fast_parallel_intake

// >>> src/fast_parallel_ratio.sv
`timescale 1ns/1ns
`include "fast_parallel_consts.svh"
module fast_parallel_ratio (
    input wire logic [1:0] width,
    input wire logic decomp_en,
    input wire logic sec_en,
    output fast_parallel_pkg::ratio_t ratio,
    output logic width_bad
);
    always_comb begin
        ratio = `RATIO_1;
        width_bad = 1'b0;
        unique case (width)
            `WIDTH_X8: begin
                if (decomp_en) ratio = `RATIO_2; // RQ1
            end
            `WIDTH_X16: begin
                if (decomp_en) ratio = `RATIO_4; // RQ2
                else if (sec_en) ratio = `RATIO_2; // RQ2
            end
            `WIDTH_X32: begin
                if (decomp_en) ratio = `RATIO_8; // RQ3
                else if (sec_en) ratio = `RATIO_4; // RQ3
            end
            default: begin
                // reserved code: run as x32 and flag it
                width_bad = 1'b1;
                if (decomp_en) ratio = `RATIO_8;
                else if (sec_en) ratio = `RATIO_4;
            end
        endcase
    end
endmodule // fast_parallel_ratio

// >>> src/fast_parallel_unpack.sv
`timescale 1ns/1ns
module fast_parallel_unpack (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic load,
    input wire logic step,
    input wire logic sec_en,
    input wire logic decomp_en,
    input wire logic [31:0] key,
    input wire logic [31:0] din,
    output logic [31:0] dout_r
);
    logic [31:0] key_r;

    // one keystream round per extra edge when sec_en is set; key rolls so rounds differ
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dout_r <= 32'h0;
            key_r <= 32'h0;
        end else if (load) begin
            dout_r <= sec_en ? (din ^ key) : din;
            key_r <= {key[30:0], key[31]};
        end else if (step) begin // RQ5
            key_r <= {key_r[30:0], key_r[31]};
            if (decomp_en)
                dout_r <= {dout_r[23:0], dout_r[31:24]} ^
                    (sec_en ? key_r : 32'h0);
            else if (sec_en)
                dout_r <= dout_r ^ key_r;
        end
    end
endmodule // fast_parallel_unpack

// >>> tb/cfg_host.sv
`timescale 1ns/1ns
module cfg_host (
    input wire logic pclk,
    output logic config_clock,
    output logic [31:0] config_data
);
    initial begin
        config_clock = 1'b0;
        config_data = 32'h0;
    end

    // clock stands low between frames; every group is run to its end
    task automatic send(input int n, input int r, input logic [31:0] base);
        for (int w = 0; w < n; w++) begin
            for (int k = 0; k < r; k++) begin
                @(posedge pclk);
                config_clock <= 1'b1;
                if (k == 0) begin
                    config_data <= base + w[31:0]; // held for whole group
                end
                @(posedge pclk);
                config_clock <= 1'b0;
            end
        end
        @(posedge pclk);
        config_data <= ~config_data; // released bus must not look stale
    endtask
endmodule // cfg_host

// >>> tb/parallel_config_clock_ratio_test.sv
`timescale 1ns/1ns
`include "fast_parallel_consts.svh"
module parallel_config_clock_ratio_test;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, config_data, word_data, last_word, rd;
    logic [31:0] mask;
    logic [3:0] exp_r;
    logic config_clock, word_valid, busy;
    int fail_count = 0;
    int checked = 0;
    int vcount = 0;
    int cycles = 0;
    int v0;

    fast_parallel_intake #(.RELEASE_CYC(8)) i_dut (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .config_clock(config_clock),
        .config_data(config_data), .word_data(word_data),
        .word_valid(word_valid), .busy(busy));
    cfg_host i_host (.pclk(pclk), .config_clock(config_clock),
        .config_data(config_data));

    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count++;
            print_verdict();
        end
        if (word_valid === 1'b1) begin
            vcount++;
            last_word = word_data;
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one apb transfer; request held until pready seen at a rising edge
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    function automatic logic [3:0] ratio_of(int w, int d, int s);
        if (d != 0) return (w == 0) ? 4'h2 : (w == 1) ? 4'h4 : 4'h8;
        if (s != 0) return (w == 0) ? 4'h1 : (w == 1) ? 4'h2 : 4'h4;
        return 4'h1;
    endfunction

    // write control, wait for run state, then the status-to-clock gap
    task automatic start(input logic [31:0] c);
        apb(1'b1, `CTRL_OFF, c);
        rd = 32'h0;
        while (rd[9:8] !== 2'h2) apb(1'b0, `STAT_OFF, 32'h0);
        repeat (`STATUS_GAP_CYC) @(posedge pclk);
    endtask

    task automatic print_verdict();
        $display("mismatches %0d, comparisons %0d", fail_count, checked);
        if (fail_count == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        // reserved width plus a clock rise inside the release wait
        apb(1'b1, `CTRL_OFF, 32'h7);
        i_host.send(1, 1, 32'h0);
        apb(1'b0, `FLAG_OFF, 32'h0);
        check(rd & 32'h5, 32'h5);
        apb(1'b1, `CTRL_OFF, 32'h0);
        apb(1'b1, `FLAG_OFF, 32'h7);
        apb(1'b0, `FLAG_OFF, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, 12'h020, 32'h0);
        check({31'h0, err}, 32'h1);
        apb(1'b1, `KEY_OFF, 32'h5a);
        apb(1'b0, `KEY_OFF, 32'h0);
        check(rd, 32'h0);
        for (int w = 0; w < 3; w++) begin
            for (int d = 0; d < 2; d++) begin
                for (int s = 0; s < 2; s++) begin
                    exp_r = ratio_of(w, d, s);
                    mask = (w == 0) ? 32'hff : (w == 1) ? 32'hffff : '1;
                    start({27'h0, s[0], d[0], w[1:0], 1'b1});
                    apb(1'b1, `COUNT_OFF, 32'h0);
                    v0 = vcount;
                    i_host.send(3, int'(exp_r), 32'hc3a5_7e18);
                    repeat (4) @(posedge pclk);
                    check(32'(vcount - v0), 32'h3);
                    apb(1'b0, `COUNT_OFF, 32'h0);
                    check(rd, 32'h3);
                    apb(1'b0, `STAT_OFF, 32'h0);
                    check({28'h0, rd[3:0]}, {28'h0, exp_r});
                    if (d == 0 && s == 0) begin
                        check(last_word, 32'hc3a5_7e1a & mask);
                    end
                    if (w == 0 && d == 0 && s == 1) begin
                        check(last_word, 32'h40);
                    end
                    apb(1'b1, `CTRL_OFF, 32'h0);
                end
            end
        end
        // drop enable inside a x16 decompress group
        start(32'hb);
        v0 = vcount;
        fork
            i_host.send(1, 4, 32'h0);
            begin
                apb(1'b1, `CTRL_OFF, 32'h0);
                check({31'h0, busy}, 32'h1);
            end
        join
        check({31'h0, busy}, 32'h0);
        check(32'(vcount - v0), 32'h0);
        apb(1'b0, `FLAG_OFF, 32'h0);
        check(rd, 32'h2);
        print_verdict();
    end
endmodule // parallel_config_clock_ratio_test
